// ===== core/smau_cfi_drv.sv
// output driver control of one configurable port bit.
// assumes code, selects and data are stable on the core clock.
`timescale 1ns/10ps
`default_nettype none
module smau_cfi_drv (
    // slot state
    input  wire logic [3:0] code,
    input  wire logic [2:0] bit_pos,
    input  wire logic       data_bit,
    // mode
    input  wire logic [1:0] sub_sel,
    input  wire logic       open_drain,
    // pin
    output logic            pin_out,
    output logic            pin_oe
);
    logic [7:0] win;
    logic       active;

    // subchannels drive only in the chosen subslot, whatever position the code names
    always_comb
    begin
        win = 8'h00;
        if (code == smau_pkg::CODE_FULL)
            win = smau_pkg::code_mask(code);                                   // R5
        else if (code[3:1] == smau_pkg::CODE_NIBBLE_PFX)
            win = smau_pkg::code_mask({smau_pkg::CODE_NIBBLE_PFX, sub_sel[0]}); // R6 R10
        else if (code[3:2] == smau_pkg::CODE_PAIR_PFX)
            win = smau_pkg::code_mask({smau_pkg::CODE_PAIR_PFX, sub_sel});      // R7 R10
        active = win[bit_pos];                                                  // R4 R9
    end

    // open drain never drives a one; an outside pull-up makes it
    assign pin_out = open_drain ? 1'b0 : data_bit;                     // R11
    assign pin_oe  = active & (open_drain ? ~data_bit : 1'b1);         // R11
endmodule // smau_cfi_drv
`default_nettype wire

// ===== core/smau_device.sv
// memory access unit: link registers, connection and data memories, tristate field.
// assumes the host keeps the poll-before-read discipline and one core clock.
//
// Overview of operation
// [R1] op 111x writes data and code fields
// [R2] read-code puts code in data low nibble
// [R3] host polls busy before reading data
// [R4] code 0000 means slot disabled
// [R5] code 0001 switches full byte
// [R6] codes 0011/0010 switch high/low nibble
// [R7] codes 0111..0100 switch bit pairs
// [R8] codes 1000,1010,1011 preprocessed, 1001 processor
// [R9] downstream code steers configurable port drivers
// [R10] subchannels drive only in selected subslot
// [R11] style bit picks tristate or open drain
// [R12] idle writes 08..38 masked by position
// [R13] command 88 reads data memory byte
// [R14] command 60 writes one tristate entry
// [R15] command 68 writes all tristate entries
// [R16] command e0 reads one tristate entry
// [R17] command 48 writes connection data field
// [R18] op 1001 leaves code field untouched
// [R19] write-all takes 1035 clock cycles
// [R20] command write sets busy until done
`timescale 1ns/10ps
`default_nettype none
module smau_device (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // register link
    smau_if.device          link,
    // mode settings
    input  wire logic [1:0] subchannel_select_reg,
    input  wire logic       output_style_select,
    // downstream configurable port bit
    input  wire logic [6:0] cfi_slot,
    input  wire logic [2:0] cfi_bit,
    output logic            cfi_out,
    output logic            cfi_oe,
    // pcm side
    input  wire logic       pcm_rx_wr,
    input  wire logic [6:0] pcm_rx_slot,
    input  wire logic [7:0] pcm_rx_byte,
    input  wire logic [6:0] pcm_tx_slot,
    input  wire logic [2:0] pcm_tx_bit,
    output logic            pcm_tx_oe,
    // per slot class flags of the connection entry at the access address register
    output logic            cfi_preproc,
    output logic            cfi_up_channel
);
    // ---
    // registers and storage
    // ---
    logic [7:0]              mem_access_command_reg_r;
    logic [7:0]              mem_access_address_reg_r;
    logic [7:0]              mem_access_data_reg_r;
    logic                    mem_access_busy_r;
    smau_pkg::smau_dev_state_e state_r;
    logic [10:0]             tri_cnt_r;
    logic [7:0]              rdata_r;
    logic                    rvalid_r;
    logic [3:0]              cm_code_r [256];
    logic [7:0]              cm_data_r [256];
    logic [7:0]              dm_data_r [256];
    logic [3:0]              tri_r     [128];

    logic       is_rd;
    logic [3:0] op;
    logic       op_code_data;
    logic       start;
    logic       exec;
    logic [7:0] idx;
    logic [6:0] tri_idx;
    logic [7:0] dm_mask;
    logic [3:0] ds_code;

    assign is_rd        = mem_access_command_reg_r[smau_pkg::CMD_RD_BIT];
    assign op           = mem_access_command_reg_r[6:3];
    assign op_code_data = (mem_access_command_reg_r[6:4] == smau_pkg::OP_CODE_DATA);
    assign start        = link.wr && (link.sel == smau_pkg::SEL_CMD) && !mem_access_busy_r;
    assign exec         = (state_r == smau_pkg::DEV_EXEC);
    assign idx          = mem_access_address_reg_r;
    assign tri_idx      = mem_access_address_reg_r[6:0];   // upstream implied
    assign dm_mask      = smau_pkg::code_mask(op);

    // ---
    // link registers
    // ---
    // a command written while busy is dropped, so a new command never replaces a running one
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mem_access_command_reg_r <= 8'h00;
        else if (start)
            mem_access_command_reg_r <= link.wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mem_access_address_reg_r <= 8'h00;
        else if (link.wr && link.sel == smau_pkg::SEL_ADDR)
            mem_access_address_reg_r <= link.wdata;
    end

    // data register takes link writes and the result of memory reads
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            mem_access_data_reg_r <= 8'h00;
        else if (exec && is_rd)
        begin
            if (op_code_data)
                mem_access_data_reg_r <= {4'h0, cm_code_r[idx]};          // R2
            else if (op == smau_pkg::OP_CM_DATA)
                mem_access_data_reg_r <= cm_data_r[idx];                  // R18
            else if (op == smau_pkg::OP_TRI_ONE)
                mem_access_data_reg_r <= {4'h0, tri_r[tri_idx]};          // R16
            else if (op == smau_pkg::OP_DM_FULL)
                mem_access_data_reg_r <= dm_data_r[idx];                  // R13
        end
        else if (link.wr && link.sel == smau_pkg::SEL_DATA)
            mem_access_data_reg_r <= link.wdata;
    end

    // read answers one cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= link.rd;
            case (link.sel)
                smau_pkg::SEL_CMD:  rdata_r <= mem_access_command_reg_r;
                smau_pkg::SEL_ADDR: rdata_r <= mem_access_address_reg_r;
                smau_pkg::SEL_DATA: rdata_r <= mem_access_data_reg_r;
                default:            rdata_r <= 8'(mem_access_busy_r) << smau_pkg::STAT_BUSY_BIT;
            endcase
        end
    end
    assign link.rdata  = rdata_r;
    assign link.rvalid = rvalid_r;

    // ---
    // sequencer
    // ---
    // busy falls on the same edge that loads read data into the data register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r           <= smau_pkg::DEV_IDLE;
            mem_access_busy_r <= 1'b0;
            tri_cnt_r         <= 11'd0;
        end
        else
        begin
            case (state_r)
                smau_pkg::DEV_IDLE:
                    if (start)
                    begin
                        mem_access_busy_r <= 1'b1;                          // R20
                        tri_cnt_r         <= 11'd0;
                        if (link.wdata[6:3] == smau_pkg::OP_TRI_ALL && !link.wdata[smau_pkg::CMD_RD_BIT])
                            state_r <= smau_pkg::DEV_TRI_ALL;
                        else
                            state_r <= smau_pkg::DEV_EXEC;
                    end
                smau_pkg::DEV_EXEC:
                begin
                    mem_access_busy_r <= 1'b0;                              // R20
                    state_r           <= smau_pkg::DEV_IDLE;
                end
                smau_pkg::DEV_TRI_ALL:
                begin
                    tri_cnt_r <= tri_cnt_r + 11'd1;
                    if (tri_cnt_r == smau_pkg::TRI_ALL_CYCLES - 11'd1)      // R19
                    begin
                        mem_access_busy_r <= 1'b0;
                        state_r           <= smau_pkg::DEV_IDLE;
                    end
                end
                default:
                begin
                    mem_access_busy_r <= 1'b0;
                    state_r           <= smau_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // ---
    // memory writes
    // ---
    // connection memory: code+data together, or data alone
    always_ff @(posedge core_clk)
    begin
        if (exec && !is_rd && op_code_data)
        begin
            cm_data_r[idx] <= mem_access_data_reg_r;                        // R1
            cm_code_r[idx] <= mem_access_command_reg_r[3:0];                // R1
        end
        else if (exec && !is_rd && op == smau_pkg::OP_CM_DATA)
            cm_data_r[idx] <= mem_access_data_reg_r;                        // R17 R18
    end

    // data memory: masked idle writes from the host, received bytes from the pcm side
    always_ff @(posedge core_clk)
    begin
        if (exec && !is_rd && dm_mask != 8'h00)
            dm_data_r[idx] <= (dm_data_r[idx] & ~dm_mask) | (mem_access_data_reg_r & dm_mask); // R12
        else if (pcm_rx_wr)
            dm_data_r[{1'b0, pcm_rx_slot}] <= pcm_rx_byte;
    end

    // tristate field; the sweep revisits entries, trading speed for a fixed duration
    always_ff @(posedge core_clk)
    begin
        if (state_r == smau_pkg::DEV_TRI_ALL)
            tri_r[tri_cnt_r[6:0]] <= mem_access_data_reg_r[3:0];            // R15
        else if (exec && !is_rd && op == smau_pkg::OP_TRI_ONE)
            tri_r[tri_idx] <= mem_access_data_reg_r[3:0];                   // R14
    end

    // ---
    // port drivers
    // ---
    assign ds_code   = cm_code_r[{1'b0, cfi_slot}];                         // R9
    assign pcm_tx_oe = tri_r[pcm_tx_slot][pcm_tx_bit[2:1]];                 // R14

    // slot class of the addressed connection entry
    assign cfi_preproc    = cm_code_r[idx][3] == smau_pkg::CODE_PREPROC_MSB
                            && cm_code_r[idx] != smau_pkg::CODE_UP_CHANNEL; // R8
    assign cfi_up_channel = cm_code_r[idx] == smau_pkg::CODE_UP_CHANNEL;    // R8

    smau_cfi_drv u_drv (
        .code       (ds_code),
        .bit_pos    (cfi_bit),
        .data_bit   (dm_data_r[cm_data_r[{1'b0, cfi_slot}]][cfi_bit]),
        .sub_sel    (subchannel_select_reg),
        .open_drain (output_style_select),
        .pin_out    (cfi_out),
        .pin_oe     (cfi_oe)
    );
endmodule // smau_device
`default_nettype wire

// ===== core/smau_host.sv
// host end: apb registers for software and a sequencer that runs the link accesses.
// assumes apb on the core clock and the device end on the other side of the link.
`timescale 1ns/10ps
`default_nettype none
module smau_host (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // link
    smau_if.host             link
);
    logic [7:0]  data_r;
    logic [7:0]  addr_r;
    logic [7:0]  cmd_r;
    logic [7:0]  result_r;
    logic        done_r;
    logic [31:0] prdata_r;
    smau_pkg::smau_host_state_e state_r;
    logic        wr_acc;
    logic        mapped;
    logic        busy;

    assign busy   = (state_r != smau_pkg::H_IDLE);
    assign mapped = paddr == smau_pkg::HREG_DATA || paddr == smau_pkg::HREG_ADDR || paddr == smau_pkg::HREG_CMD
                    || paddr == smau_pkg::HREG_STATUS || paddr == smau_pkg::HREG_RESULT;
    assign wr_acc = psel && penable && pwrite && mapped;

    // ---
    // apb side
    // ---
    // zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_r;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            prdata_r <= 32'h0;
        else if (psel && !penable)
            case (paddr)
                smau_pkg::HREG_DATA:   prdata_r <= {24'h0, data_r};
                smau_pkg::HREG_ADDR:   prdata_r <= {24'h0, addr_r};
                smau_pkg::HREG_CMD:    prdata_r <= {24'h0, cmd_r};
                smau_pkg::HREG_STATUS: prdata_r <= (32'(busy) << smau_pkg::HST_BUSY_BIT)
                                                 | (32'(done_r) << smau_pkg::HST_DONE_BIT);
                smau_pkg::HREG_RESULT: prdata_r <= {24'h0, result_r};
                default:               prdata_r <= 32'h0;
            endcase
    end

    // operand registers are frozen while a sequence runs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_r <= 8'h00;
            addr_r <= 8'h00;
            cmd_r  <= 8'h00;
        end
        else if (wr_acc && !busy)
        begin
            if (paddr == smau_pkg::HREG_DATA)
                data_r <= pwdata[7:0];
            if (paddr == smau_pkg::HREG_ADDR)
                addr_r <= pwdata[7:0];
            if (paddr == smau_pkg::HREG_CMD)
                cmd_r <= pwdata[7:0];
        end
    end

    // ---
    // sequencer
    // ---
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r  <= smau_pkg::H_IDLE;
            done_r   <= 1'b0;
            result_r <= 8'h00;
        end
        else
        begin
            case (state_r)
                smau_pkg::H_IDLE:
                    if (wr_acc && paddr == smau_pkg::HREG_CMD)
                    begin
                        done_r  <= 1'b0;
                        state_r <= smau_pkg::H_WDATA;
                    end
                smau_pkg::H_WDATA: state_r <= smau_pkg::H_WADDR;
                smau_pkg::H_WADDR: state_r <= smau_pkg::H_WCMD;
                smau_pkg::H_WCMD:  state_r <= smau_pkg::H_POLL;
                smau_pkg::H_POLL:  state_r <= smau_pkg::H_PWAIT;
                smau_pkg::H_PWAIT:
                    if (link.rvalid)
                    begin
                        if (link.rdata[smau_pkg::STAT_BUSY_BIT])
                            state_r <= smau_pkg::H_POLL;        // R3
                        else if (cmd_r[smau_pkg::CMD_RD_BIT])
                            state_r <= smau_pkg::H_RD;          // R3
                        else
                        begin
                            done_r  <= 1'b1;
                            state_r <= smau_pkg::H_IDLE;
                        end
                    end
                smau_pkg::H_RD:    state_r <= smau_pkg::H_RWAIT;
                smau_pkg::H_RWAIT:
                    if (link.rvalid)
                    begin
                        result_r <= link.rdata;
                        done_r   <= 1'b1;
                        state_r  <= smau_pkg::H_IDLE;
                    end
                default: state_r <= smau_pkg::H_IDLE;
            endcase
        end
    end

    // link strobes follow the state; data is taken from operand flops
    always_comb
    begin
        link.wr    = 1'b0;
        link.rd    = 1'b0;
        link.sel   = smau_pkg::SEL_STATUS;
        link.wdata = 8'h00;
        case (state_r)
            smau_pkg::H_WDATA: begin link.wr = 1'b1; link.sel = smau_pkg::SEL_DATA; link.wdata = data_r; end
            smau_pkg::H_WADDR: begin link.wr = 1'b1; link.sel = smau_pkg::SEL_ADDR; link.wdata = addr_r; end
            smau_pkg::H_WCMD:  begin link.wr = 1'b1; link.sel = smau_pkg::SEL_CMD;  link.wdata = cmd_r;  end
            smau_pkg::H_POLL:  link.rd = 1'b1;
            smau_pkg::H_RD:    begin link.rd = 1'b1; link.sel = smau_pkg::SEL_DATA; end
            default:           link.rd = 1'b0;
        endcase
    end
endmodule // smau_host
`default_nettype wire

// ===== core/smau_if.sv
// register link between the host controller and the memory access unit.
// assumes one shared clock; the device answers reads one cycle after rd.
`timescale 1ns/10ps
`default_nettype none
interface smau_if (input wire logic core_clk);
    logic [1:0] sel;     // register select
    logic       wr;      // write strobe
    logic       rd;      // read strobe
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;  // read data valid, one cycle

    modport device (input sel, wr, rd, wdata, output rdata, rvalid);
    modport host   (output sel, wr, rd, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

// ===== core/smau_pkg.sv
// shared constants: link selects, operation codes, field layouts, timing, host map.
// assumes both ends and the bench compile this package first.
package smau_pkg;
    // ---
    // link register selects (device side registers)
    // ---
    localparam logic [1:0] SEL_CMD    = 2'h0;
    localparam logic [1:0] SEL_ADDR   = 2'h1;
    localparam logic [1:0] SEL_DATA   = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;
    localparam int         STAT_BUSY_BIT = 0;
    // ---
    // command layout: bit 7 read, bits 6..3 operation, bits 3..0 code
    // ---
    localparam int         CMD_RD_BIT   = 7;
    localparam logic [2:0] OP_CODE_DATA = 3'h7;   // cmd[6:4], code bits in cmd[3:0]
    localparam logic [3:0] OP_CM_DATA   = 4'h9;   // data field only
    localparam logic [3:0] OP_TRI_ONE   = 4'hc;
    localparam logic [3:0] OP_TRI_ALL   = 4'hd;
    localparam logic [3:0] OP_DM_FULL   = 4'h1;   // dm read / 8 bit idle write
    // ---
    // connection codes
    // ---
    localparam logic [3:0] CODE_DISABLED = 4'h0;
    localparam logic [3:0] CODE_FULL     = 4'h1;
    localparam logic [3:0] CODE_SUB_LO   = 4'h2;
    localparam logic [3:0] CODE_SUB_HI   = 4'h7;
    localparam logic [2:0] CODE_NIBBLE_PFX = 3'h1; // 001x
    localparam logic [1:0] CODE_PAIR_PFX   = 2'h1; // 01xx
    localparam logic       CODE_PREPROC_MSB = 1'b1;
    localparam logic [3:0] CODE_UP_CHANNEL  = 4'h9;
    // ---
    // timing, in core clock cycles, and the upstream address bit
    // ---
    localparam logic [10:0] TRI_ALL_CYCLES = 11'd1035;
    localparam int          UP_DIR_BIT     = 7;   // address bit marking upstream
    // ---
    // host apb map (byte addresses)
    // ---
    localparam logic [7:0] HREG_DATA   = 8'h00;
    localparam logic [7:0] HREG_ADDR   = 8'h04;
    localparam logic [7:0] HREG_CMD    = 8'h08;
    localparam logic [7:0] HREG_STATUS = 8'h0c;
    localparam logic [7:0] HREG_RESULT = 8'h10;
    localparam int         HST_BUSY_BIT = 0;
    localparam int         HST_DONE_BIT = 1;

    typedef enum logic [1:0] {DEV_IDLE = 2'b00, DEV_EXEC = 2'b01, DEV_TRI_ALL = 2'b11} smau_dev_state_e;
    typedef enum logic [2:0] {H_IDLE = 3'b000, H_WDATA = 3'b001, H_WADDR = 3'b011, H_WCMD = 3'b010,
                              H_POLL = 3'b110, H_PWAIT = 3'b111, H_RD = 3'b101, H_RWAIT = 3'b100} smau_host_state_e;

    // byte-lane mask of a switching code, shared by memory writes and output drivers
    function automatic logic [7:0] code_mask(input logic [3:0] code);
        case (code)
            4'h1:    code_mask = 8'hff;
            4'h3:    code_mask = 8'hf0;
            4'h2:    code_mask = 8'h0f;
            4'h7:    code_mask = 8'hc0;
            4'h6:    code_mask = 8'h30;
            4'h5:    code_mask = 8'h0c;
            4'h4:    code_mask = 8'h03;
            default: code_mask = 8'h00;
        endcase
    endfunction
endpackage

// ===== dv/smau_checker.sv
// link checker: order, answers and busy timing seen between the two ends.
// assumes the link signals of the testbench, one clock, reset low.
`timescale 1ns/10ps
`default_nettype none
module smau_checker (
    // link
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [1:0] sel,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [11:0] tcnt_r;
    logic [1:0]  rsel_r;
    logic        lbusy_r;
    // cycles since a write-all command; any other command stops the count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n) tcnt_r <= 12'h000;
        else if (wr && sel == smau_pkg::SEL_CMD) tcnt_r <= {11'h000, wdata == 8'h68};
        else if (tcnt_r != 12'h000 && tcnt_r != 12'hfff) tcnt_r <= tcnt_r + 12'h001;
    end
    // last register read and last busy answer; a command counts as busy until polled
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || (wr && sel == smau_pkg::SEL_CMD)) lbusy_r <= 1'h1;
        else if (rvalid && rsel_r == smau_pkg::SEL_STATUS) lbusy_r <= rdata[0];
        if (!rst_n) rsel_r <= 2'h0;
        else if (rd) rsel_r <= sel;
    end
    sequence s_cmd_wr;
        wr && sel == smau_pkg::SEL_CMD;
    endsequence
    sequence s_status_poll;
        rd && sel == smau_pkg::SEL_STATUS;
    endsequence
    a_rd_answer: assert property (rd |=> rvalid)
        else $error("read not answered");
    a_addr_order: assert property (wr && sel == smau_pkg::SEL_ADDR |-> $past(wr) && $past(sel) == smau_pkg::SEL_DATA)
        else $error("address not after data");
    a_cmd_order: assert property (s_cmd_wr |-> $past(wr) && $past(sel) == smau_pkg::SEL_ADDR)
        else $error("command not after address");
    a_poll_after_cmd: assert property (s_cmd_wr |=> s_status_poll)
        else $error("no poll after command");
    a_triall_busy: assert property (s_cmd_wr ##0 wdata == 8'h68 |=> s_status_poll ##1 rvalid && rdata[0])
        else $error("busy not set");
    a_triall_hold: assert property (rvalid && rsel_r == 2'h3 && tcnt_r != 12'h000 && tcnt_r < 12'h40a |-> rdata[0])
        else $error("write-all ended early");
    a_triall_end: assert property (rvalid && rsel_r == 2'h3 && tcnt_r > 12'h40e |-> !rdata[0])
        else $error("write-all ended late");
    a_read_after_idle: assert property (rd && sel == smau_pkg::SEL_DATA |-> !lbusy_r)
        else $error("data read while busy");
endmodule // smau_checker
`default_nettype wire

// ===== dv/switch_memory_access_unit_tb.sv
// testbench: apb host end and device end joined by the link, driven through apb.
// assumes the package, the interface and both ends compiled first.
`timescale 1ns/10ps
`default_nettype none
module switch_memory_access_unit_tb;
    logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pcm_rx_wr = 1'h0;
    logic output_style_select = 1'h0, pready, pslverr, cfi_out, cfi_oe, pcm_tx_oe, cfi_preproc, cfi_up_channel, perr;
    logic [7:0] paddr = 8'h00, pcm_rx_byte = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [6:0] cfi_slot = 7'h00, pcm_rx_slot = 7'h00, pcm_tx_slot = 7'h00;
    logic [2:0] cfi_bit = 3'h0, pcm_tx_bit = 3'h0;
    logic [1:0] subchannel_select_reg = 2'h0;
    logic [7:0] icmd [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
    logic [7:0] imask [7] = '{8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30, 8'h0c, 8'h03};
    logic [7:0] pat = 8'ha5;
    int errors = 0, samples_checked = 0;
    always #25 core_clk = ~core_clk;
    smau_if link (.core_clk);
    smau_host u_smau_host (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link);
    smau_device u_smau_device (.core_clk, .rst_n, .link, .subchannel_select_reg, .output_style_select, .cfi_slot,
        .cfi_bit, .cfi_out, .cfi_oe, .pcm_rx_wr, .pcm_rx_slot, .pcm_rx_byte, .pcm_tx_slot, .pcm_tx_bit, .pcm_tx_oe,
        .cfi_preproc, .cfi_up_channel);
    smau_checker u_smau_checker (.core_clk, .rst_n, .sel(link.sel), .wr(link.wr), .rd(link.rd), .wdata(link.wdata),
        .rdata(link.rdata), .rvalid(link.rvalid));
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bail;
        errors++;
        $display("[FAIL] %0t wait expired", $time);
        tally_and_finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge; idle cycle after it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge core_clk);
            if (++n > 20) bail;
        end
        while (pready !== 1'h1);
        q = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask
    // data, address, command, poll busy, then fetch the result
    task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        apb(1'h1, smau_pkg::HREG_DATA, {24'h0, d});
        apb(1'h1, smau_pkg::HREG_ADDR, {24'h0, a});
        apb(1'h1, smau_pkg::HREG_CMD, {24'h0, c});
        do
        begin
            apb(1'h0, smau_pkg::HREG_STATUS, 32'h0);
            if (++n > 600) bail;
        end
        while (q[smau_pkg::HST_BUSY_BIT] !== 1'h0);
        apb(1'h0, smau_pkg::HREG_RESULT, 32'h0);
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        apb(1'h0, 8'h20, 32'h0);
        chk(perr, 32'h1);
        // every code written with data, read back and classified
        for (int c = 0; c < 16; c++)
        begin
            op({4'h7, c[3:0]}, 8'h7b, 8'hc6);
            op(8'hf0, 8'h7b, 8'h00);
            chk(q & 32'hf, c);
            chk({cfi_preproc, cfi_up_channel}, {c[3] && c != 9, c == 9});
        end
        op(8'h48, 8'h7b, 8'h3c);
        op(8'hc8, 8'h7b, 8'h00);
        chk(q, 32'h3c);
        op(8'hf0, 8'h7b, 8'h00);
        chk(q & 32'hf, 32'hf);
        // idle writes land only in the lanes of their command
        for (int i = 0; i < 7; i++)
        begin
            op(8'h08, 8'h90, 8'h00);
            op(icmd[i], 8'h90, 8'hff);
            op(8'h88, 8'h90, 8'h00);
            chk(q, {24'h0, imask[i]});
        end
        pcm_rx_slot <= 7'h05;
        pcm_rx_byte <= pat;
        pcm_rx_wr <= 1'h1;
        @(posedge core_clk);
        pcm_rx_wr <= 1'h0;
        op(8'h88, 8'h05, 8'h00);
        chk(q, {24'h0, pat});
        op(8'h71, 8'h03, 8'h05);
        cfi_slot <= 7'h03;
        // full channel in both output styles
        for (int k = 0; k < 16; k++)
        begin
            cfi_bit <= k[2:0];
            output_style_select <= k[3];
            @(negedge core_clk);
            chk({cfi_oe, cfi_out & cfi_oe}, k[3] ? {!pat[k[2:0]], 1'h0} : {1'h1, pat[k[2:0]]});
            @(posedge core_clk);
        end
        output_style_select <= 1'h0;
        subchannel_select_reg <= 2'h1;
        // disabled slot, high nibble, then a bit pair in subslot 1
        for (int m = 0; m < 3; m++)
        begin
            op(8'h70 + 8'(m * 3), 8'h03, 8'h05);
            for (int k = 0; k < 8; k++)
            begin
                cfi_bit <= k[2:0];
                @(negedge core_clk);
                chk(cfi_oe, m == 1 && k > 3 || m == 2 && k[2:1] == 2'h1);
                @(posedge core_clk);
            end
        end
        op(8'h60, 8'haa, 8'h09);
        op(8'he0, 8'haa, 8'h00);
        chk(q & 32'hf, 32'h9);
        pcm_tx_slot <= 7'h2a;
        for (int k = 0; k < 8; k++)
        begin
            pcm_tx_bit <= k[2:0];
            @(negedge core_clk);
            chk(pcm_tx_oe, (8'hc3 >> k) & 8'h01);
            @(posedge core_clk);
        end
        op(8'h68, 8'h00, 8'h0f);
        op(8'he0, 8'h85, 8'h00);
        chk(q & 32'hf, 32'hf);
        tally_and_finish;
    end
endmodule // switch_memory_access_unit_tb
`default_nettype wire
